// ==== rtl/ccd_pkg.sv ====
// Function
// [R1] Low phase lasts low-count field plus one divider input cycles.
// [R2] High phase lasts high-count field plus one divider input cycles.
// [R3] Bypass set: divider idles, its input clock goes straight to its output.
// [R4] Sync-ignore clear: divider obeys the chip-level sync; set: ignores it.
// [R5] Force-high drives output statically high, only with sync-ignore also set.
// [R6] With force-high clear the static forced level is low.
// [R7] Force-high has no effect while bypass is set.
// [R8] Start-level bit picks whether the waveform begins high or low.
// [R9] Four-bit phase offset field sets coarse phase, resets to zero.
// [R10] Direct-route clear: third pair driven by second channel divider.
// [R11] Direct-route set with source 10b: VCO clock goes straight to pair.
// [R12] Direct-route set with source 00b: external clock goes straight to pair.
// [R13] Direct-route set with source 01b: no effect, pair stays on divider.
// [R14] First channel direct-route: clear uses its divider, set routes like others.
// [R15] Duty-cycle correction applies while its disable bit is clear.
// [R16] Source bit 1 picks VCO when set, external clock when clear.
// [R17] After sync release, restart at start level after phase-offset input cycles.
`default_nettype none
package ccd_pkg;

    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CH1_ROUTE = 10'h195;
    localparam logic [IDX_W-1:0] IDX_CH2_COUNTS = 10'h196;
    localparam logic [IDX_W-1:0] IDX_CH2_CTRL = 10'h197;
    localparam logic [IDX_W-1:0] IDX_CH2_ROUTE = 10'h198;
    localparam logic [IDX_W-1:0] IDX_SRC_SEL = 10'h1E1;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h1F0;

    localparam logic [7:0] RST_CH1_ROUTE = 8'h00;
    localparam logic [7:0] RST_CH2_COUNTS = 8'h00;
    localparam logic [7:0] RST_CH2_CTRL = 8'h00;
    localparam logic [7:0] RST_CH2_ROUTE = 8'h00;
    localparam logic [7:0] RST_SRC_SEL = 8'h00;

    // Field positions
    localparam int LOW_LSB = 4;
    localparam int HIGH_LSB = 0;
    localparam int CNT_W = 4;
    localparam int BIT_BYPASS = 7;
    localparam int BIT_NOSYNC = 6;
    localparam int BIT_FORCE_HIGH = 5;
    localparam int BIT_START_HIGH = 4;
    localparam int PHASE_LSB = 0;
    localparam int BIT_DIRECT = 1;
    localparam int BIT_DCC_OFF = 0;
    localparam int BIT_SRC_VCO = 1;

    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_VCO = 2'h2;

    // Status bits
    localparam int ST_DIV_OUT = 0;
    localparam int ST_SYNC_HOLD = 1;
    localparam int ST_SECOND = 2;
    localparam int ST_THIRD = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DIV_HOLD, DIV_DELAY, DIV_RUN} ccd_div_state_t;

endpackage
`default_nettype wire

// ==== rtl/ccd_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccd_divider
    import ccd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_edge,
    input wire logic [CNT_W-1:0] low_cnt,
    input wire logic [CNT_W-1:0] high_cnt,
    input wire logic start_high,
    input wire logic [CNT_W-1:0] phase_off,
    input wire logic sync_hold,
    input wire logic force_on,
    input wire logic power_down,
    output logic div_out
);

    ccd_div_state_t state_r, state_nxt;
    logic level_r, level_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic out_r;
    logic toggle_ev;
    logic phase_start;
    logic [CNT_W:0] ph_edges_r;
    logic clean_r;
    logic [2*CNT_W-1:0] fields_r;

    assign toggle_ev = (state_r == DIV_RUN) && in_edge && (cnt_r == '0) && !sync_hold && !power_down;
    assign phase_start = toggle_ev || ((state_nxt == DIV_RUN) && (state_r != DIV_RUN));

    always_comb begin
        state_nxt = state_r;
        level_nxt = level_r;
        cnt_nxt = cnt_r;
        case (state_r)
            DIV_HOLD: begin
                level_nxt = 1'b0; // R6
                if (phase_off == '0) begin
                    state_nxt = DIV_RUN; // R17
                    level_nxt = start_high; // R8
                    cnt_nxt = start_high ? high_cnt : low_cnt;
                end else begin
                    state_nxt = DIV_DELAY; // R9
                    cnt_nxt = phase_off - 1'b1;
                end
            end
            DIV_DELAY: begin
                level_nxt = 1'b0;
                if (in_edge) begin
                    if (cnt_r == '0) begin
                        state_nxt = DIV_RUN; // R17
                        level_nxt = start_high; // R8
                        cnt_nxt = start_high ? high_cnt : low_cnt;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
            end
            DIV_RUN: begin
                if (in_edge) begin
                    if (cnt_r == '0) begin
                        level_nxt = !level_r;
                        cnt_nxt = level_r ? low_cnt : high_cnt; // R1 R2
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = DIV_HOLD;
            end
        endcase
        // Bypass powers the counters down; leaving it restarts like a sync release
        if (sync_hold || power_down) begin
            state_nxt = DIV_HOLD;
            level_nxt = 1'b0; // R6
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= DIV_HOLD;
            level_r <= 1'b0;
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
            out_r <= force_on ? 1'b1 : level_nxt; // R5
        end
    end

    assign div_out = out_r;

    // Phase length bookkeeping, read only by the checks below
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_edges_r <= '0;
            clean_r <= 1'b0;
            fields_r <= '0;
        end else begin
            fields_r <= {low_cnt, high_cnt};
            if (phase_start) begin
                ph_edges_r <= '0;
                clean_r <= 1'b1;
            end else begin
                if (in_edge) begin
                    ph_edges_r <= ph_edges_r + 1'b1;
                end
                clean_r <= clean_r && ({low_cnt, high_cnt} == fields_r);
            end
        end
    end

    a_low_phase_len: assert property (@(posedge clk) disable iff (rst) // R1
        toggle_ev && clean_r && !level_r |-> ph_edges_r == {1'b0, low_cnt})
        else $error("low phase length differs from field plus one");
    a_high_phase_len: assert property (@(posedge clk) disable iff (rst) // R2
        toggle_ev && clean_r && level_r |-> ph_edges_r == {1'b0, high_cnt})
        else $error("high phase length differs from field plus one");
    a_force_high_out: assert property (@(posedge clk) disable iff (rst) // R5
        force_on |=> div_out)
        else $error("forced output not high");
    a_hold_low_out: assert property (@(posedge clk) disable iff (rst) // R6
        (sync_hold || power_down) && !force_on |=> !div_out && state_r == DIV_HOLD)
        else $error("held divider output not low");
    a_start_level: assert property (@(posedge clk) disable iff (rst) // R8
        state_r != DIV_RUN && state_nxt == DIV_RUN && !force_on |=> div_out == $past(start_high))
        else $error("waveform did not begin at start level");
    a_phase_delay: assert property (@(posedge clk) disable iff (rst) // R17
        state_r == DIV_HOLD && !sync_hold && !power_down && phase_off != '0
        |=> state_r == DIV_DELAY && cnt_r == $past(phase_off) - 1'b1 && (!div_out || $past(force_on)))
        else $error("phase offset delay not entered");

    c_run_toggle: cover property (@(posedge clk) disable iff (rst) toggle_ev && clean_r);
    c_delay_exit: cover property (@(posedge clk) disable iff (rst)
        state_r == DIV_DELAY ##1 state_r == DIV_RUN);

endmodule // ccd_divider
`default_nettype wire

// ==== rtl/ccd_channel_clock.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccd_channel_clock
    import ccd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic vco_clk,
    input wire logic ext_clk,
    input wire logic sync_req,
    input wire logic ch1_div_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic second_pair_out_a,
    output logic second_pair_out_b,
    output logic third_pair_out_a,
    output logic third_pair_out_b
);

    // Pin synchronisers: vco, ext, sync
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic vco_s;
    logic ext_s;
    logic sync_s;
    logic sel_s;
    logic sel_prev_r;
    logic in_edge;

    // Registers
    logic [1:0] ch1_route_r;
    logic [7:0] ch2_counts_r;
    logic [7:0] ch2_ctrl_r;
    logic [1:0] ch2_route_r;
    logic [1:0] src_sel_r;

    // Write channel
    logic aw_have_r, aw_have_nxt;
    logic w_have_r, w_have_nxt;
    logic [IDX_W-1:0] aw_idx_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic wr_lane;
    logic wr_ch1_route;
    logic wr_ch2_counts;
    logic wr_ch2_ctrl;
    logic wr_ch2_route;
    logic wr_src_sel;
    logic wr_mapped;

    // Read channel
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic ar_take;
    logic [IDX_W-1:0] rd_idx;
    logic rd_mapped;
    logic [7:0] rd_byte;

    // Divider and routing
    logic bypass;
    logic nosync;
    logic sync_hold;
    logic force_on;
    logic ch2_div_out;
    logic [1:0] direct_bit;
    logic [1:0] dcc_off;
    logic [1:0] div_path;
    logic [1:0] raw_clk;
    logic [1:0] prev_r;
    logic [1:0] out_r;
    logic direct_vco;
    logic direct_ext;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            sel_prev_r <= 1'b0;
        end else begin
            pin_s1_r <= {sync_req, ext_clk, vco_clk};
            pin_s2_r <= pin_s1_r;
            sel_prev_r <= sel_s;
        end
    end

    assign vco_s = pin_s2_r[0];
    assign ext_s = pin_s2_r[1];
    assign sync_s = pin_s2_r[2];
    assign sel_s = src_sel_r[BIT_SRC_VCO] ? vco_s : ext_s; // R16
    assign in_edge = sel_s && !sel_prev_r;

    // Write path: address and data may arrive in either order
    assign aw_take = s_axi_awvalid && awready_r;
    assign w_take = s_axi_wvalid && wready_r;
    assign do_write = aw_have_r && w_have_r && !bvalid_r;
    assign wr_lane = do_write && wstrb0_r;
    assign wr_ch1_route = wr_lane && (aw_idx_r == IDX_CH1_ROUTE);
    assign wr_ch2_counts = wr_lane && (aw_idx_r == IDX_CH2_COUNTS);
    assign wr_ch2_ctrl = wr_lane && (aw_idx_r == IDX_CH2_CTRL);
    assign wr_ch2_route = wr_lane && (aw_idx_r == IDX_CH2_ROUTE);
    assign wr_src_sel = wr_lane && (aw_idx_r == IDX_SRC_SEL);
    assign wr_mapped = (aw_idx_r == IDX_CH1_ROUTE) || (aw_idx_r == IDX_CH2_COUNTS) ||
                       (aw_idx_r == IDX_CH2_CTRL) || (aw_idx_r == IDX_CH2_ROUTE) ||
                       (aw_idx_r == IDX_SRC_SEL) || (aw_idx_r == IDX_STATUS);
    assign aw_have_nxt = (aw_have_r || aw_take) && !do_write;
    assign w_have_nxt = (w_have_r || w_take) && !do_write;
    assign bvalid_nxt = do_write || (bvalid_r && !s_axi_bready);
    assign awready_nxt = !aw_have_nxt && !bvalid_nxt && !do_write;
    assign wready_nxt = !w_have_nxt && !bvalid_nxt && !do_write;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_take) begin
                aw_idx_r <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch1_route_r <= RST_CH1_ROUTE[1:0];
            ch2_counts_r <= RST_CH2_COUNTS;
            ch2_ctrl_r <= RST_CH2_CTRL;
            ch2_route_r <= RST_CH2_ROUTE[1:0];
            src_sel_r <= RST_SRC_SEL[1:0];
        end else begin
            if (wr_ch1_route) begin
                ch1_route_r <= wdata_r[1:0];
            end
            if (wr_ch2_counts) begin
                ch2_counts_r <= wdata_r;
            end
            if (wr_ch2_ctrl) begin
                ch2_ctrl_r <= wdata_r;
            end
            if (wr_ch2_route) begin
                ch2_route_r <= wdata_r[1:0];
            end
            if (wr_src_sel) begin
                src_sel_r <= wdata_r[1:0];
            end
        end
    end

    // Read path
    assign ar_take = s_axi_arvalid && arready_r;
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];
    assign rd_mapped = (rd_idx == IDX_CH1_ROUTE) || (rd_idx == IDX_CH2_COUNTS) ||
                       (rd_idx == IDX_CH2_CTRL) || (rd_idx == IDX_CH2_ROUTE) ||
                       (rd_idx == IDX_SRC_SEL) || (rd_idx == IDX_STATUS);
    assign rd_byte = (rd_idx == IDX_CH1_ROUTE) ? {6'h00, ch1_route_r} :
                     (rd_idx == IDX_CH2_COUNTS) ? ch2_counts_r :
                     (rd_idx == IDX_CH2_CTRL) ? ch2_ctrl_r :
                     (rd_idx == IDX_CH2_ROUTE) ? {6'h00, ch2_route_r} :
                     (rd_idx == IDX_SRC_SEL) ? {6'h00, src_sel_r} :
                     (rd_idx == IDX_STATUS) ? {4'h0, out_r[1], out_r[0], sync_hold, ch2_div_out} :
                     8'h00;
    assign rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);
    assign arready_nxt = !rvalid_nxt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= {24'h000000, rd_byte};
                rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Second channel divider
    assign bypass = ch2_ctrl_r[BIT_BYPASS];
    assign nosync = ch2_ctrl_r[BIT_NOSYNC];
    assign sync_hold = sync_s && !nosync; // R4
    assign force_on = nosync && ch2_ctrl_r[BIT_FORCE_HIGH] && !bypass; // R5 R7

    ccd_divider u_div2 (
        .clk(clk),
        .rst(rst),
        .in_edge(in_edge),
        .low_cnt(ch2_counts_r[LOW_LSB +: CNT_W]),
        .high_cnt(ch2_counts_r[HIGH_LSB +: CNT_W]),
        .start_high(ch2_ctrl_r[BIT_START_HIGH]),
        .phase_off(ch2_ctrl_r[PHASE_LSB +: CNT_W]),
        .sync_hold(sync_hold),
        .force_on(force_on),
        .power_down(bypass),
        .div_out(ch2_div_out)
    );

    // Index 0 is the second pair (first channel), index 1 the third pair
    assign direct_bit = {ch2_route_r[BIT_DIRECT], ch1_route_r[BIT_DIRECT]};
    assign dcc_off = {ch2_route_r[BIT_DCC_OFF], ch1_route_r[BIT_DCC_OFF]};
    assign div_path = {bypass ? sel_s : ch2_div_out, ch1_div_out}; // R3
    // Source 01b and the unused 11b leave the pair on its divider
    assign direct_vco = src_sel_r == SRC_VCO;
    assign direct_ext = src_sel_r == SRC_EXT;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_pair
            assign raw_clk[ch] = !direct_bit[ch] ? div_path[ch] : // R10 R14
                                 direct_vco ? vco_s : // R11
                                 direct_ext ? ext_s : // R12
                                 div_path[ch]; // R13
            // Correction drops a level seen in only one sample
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    prev_r[ch] <= 1'b0;
                    out_r[ch] <= 1'b0;
                end else begin
                    prev_r[ch] <= raw_clk[ch];
                    if (dcc_off[ch] || (raw_clk[ch] == prev_r[ch])) begin
                        out_r[ch] <= raw_clk[ch]; // R15
                    end
                end
            end
        end
    endgenerate

    assign second_pair_out_a = out_r[0];
    assign second_pair_out_b = out_r[0];
    assign third_pair_out_a = out_r[1];
    assign third_pair_out_b = out_r[1];

    a_bypass_route: assert property (@(posedge clk) disable iff (rst) // R3
        bypass && !direct_bit[1] && dcc_off[1] |=> third_pair_out_a == $past(sel_s))
        else $error("bypass does not pass input clock");
    a_div_route: assert property (@(posedge clk) disable iff (rst) // R10
        !bypass && !direct_bit[1] && dcc_off[1] |=> third_pair_out_a == $past(ch2_div_out))
        else $error("third pair not on divider");
    a_direct_vco: assert property (@(posedge clk) disable iff (rst) // R11
        direct_bit[1] && src_sel_r == SRC_VCO && dcc_off[1] |=> third_pair_out_a == $past(vco_s))
        else $error("vco not routed to third pair");
    a_direct_ext: assert property (@(posedge clk) disable iff (rst) // R12
        direct_bit[1] && src_sel_r == SRC_EXT && dcc_off[1] |=> third_pair_out_b == $past(ext_s))
        else $error("external clock not routed to third pair");
    a_direct_none: assert property (@(posedge clk) disable iff (rst) // R13
        direct_bit[1] && src_sel_r == 2'h1 && !bypass && dcc_off[1] |=> third_pair_out_a == $past(ch2_div_out))
        else $error("source 01b changed routing");
    a_ch1_route: assert property (@(posedge clk) disable iff (rst) // R14
        !direct_bit[0] && dcc_off[0] |=> second_pair_out_a == $past(ch1_div_out))
        else $error("second pair not on first divider");
    a_sync_holds: assert property (@(posedge clk) disable iff (rst) // R4
        sync_s && !nosync && !bypass ##1 sync_s && !nosync |=> !ch2_div_out)
        else $error("divider ran during sync");
    a_dcc_filter: assert property (@(posedge clk) disable iff (rst) // R15
        !dcc_off[1] && raw_clk[1] != $past(raw_clk[1]) |=> third_pair_out_a == $past(third_pair_out_a))
        else $error("single-sample level passed correction");

    c_vco_direct: cover property (@(posedge clk) disable iff (rst) direct_bit[1] && direct_vco);
    c_bypass: cover property (@(posedge clk) disable iff (rst) bypass && $rose(third_pair_out_a));
    c_sync_release: cover property (@(posedge clk) disable iff (rst) $fell(sync_hold));
    c_force: cover property (@(posedge clk) disable iff (rst) force_on ##1 third_pair_out_a);

endmodule // ccd_channel_clock
`default_nettype wire

// ==== tb/channel_clock_divider_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module channel_clock_divider_tb
    import ccd_pkg::*;
();
logic clk = 0, rst = 1, vco = 0, ext = 0, sync_req = 0, ch1 = 0;
logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [31:0] wdata = '0, rdata;
logic awready, wready, bvalid, arready, rvalid, o2a, o2b, o3a, o3b;
logic [1:0] bresp, rresp;
int bad_count = 0, comparisons = 0, ph = 0;

ccd_channel_clock DUT (.clk(clk), .rst(rst), .vco_clk(vco), .ext_clk(ext), .sync_req(sync_req),
    .ch1_div_out(ch1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .second_pair_out_a(o2a),
    .second_pair_out_b(o2b), .third_pair_out_a(o3a), .third_pair_out_b(o3b));

always #5 clk = ~clk;
// Source clocks: ext period 4, vco period 6, first channel period 10
always @(posedge clk) begin
    ph <= (ph == 59) ? 0 : ph + 1;
    ext <= (ph % 4) < 2;
    vco <= (ph % 6) < 3;
    ch1 <= (ph % 10) < 5;
end

task automatic stop_test();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
        bad_count++;
        $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
endtask

task automatic tmo(input logic ok);
    if (!ok) begin
        bad_count++;
        stop_test();
    end
endtask

task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic a, w, b;
    int n;
    b = 0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 40 && !b; n++) begin
        @(negedge clk);
        a = awvalid && awready;
        w = wvalid && wready;
        b = bvalid === 1'b1;
        if (b) chk("bresp", RESP_OKAY, bresp);
        @(posedge clk);
        if (a) awvalid <= 0;
        if (w) wvalid <= 0;
        if (b) bready <= 0;
    end
    tmo(b);
endtask

task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic a, r;
    int n;
    r = 0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 40 && !r; n++) begin
        @(negedge clk);
        a = arvalid && arready;
        r = rvalid === 1'b1;
        if (r) chk("rdata", {24'h0, e}, rdata);
        if (r) chk("rresp", er, rresp);
        @(posedge clk);
        if (a) arvalid <= 0;
        if (r) rready <= 0;
    end
    tmo(r);
endtask

function automatic logic osel(input int s);
    return s ? o3a : o2a;
endfunction

// Length in clk cycles of the next full phase at level v
task automatic len(input string nm, input int s, input logic v, input int e);
    int n, l;
    n = 0;
    l = 0;
    while (osel(s) === v && n < 300) begin @(negedge clk); n++; end
    while (osel(s) !== v && n < 600) begin @(negedge clk); n++; end
    while (osel(s) === v && n < 900) begin @(negedge clk); n++; l++; end
    tmo(n < 900);
    chk(nm, e, l);
endtask

task automatic steady(input string nm, input logic v);
    int n, c;
    c = 0;
    // Pin sync, divider and correction stages delay a control change
    repeat (8) @(negedge clk);
    for (n = 0; n < 40; n++) begin @(negedge clk); c += (o3a === v); end
    chk(nm, 40, c);
endtask

// Cycles from sync release, at a fixed source phase, to first high output
task automatic sync_lat(input logic [7:0] ctrl, output int t);
    wr(IDX_CH2_CTRL, ctrl);
    sync_req <= 1;
    repeat (20) @(negedge clk);
    while (ph != 0) @(negedge clk);
    @(posedge clk);
    sync_req <= 0;
    t = 0;
    while (o3a !== 1'b1 && t < 300) begin @(negedge clk); t++; end
    tmo(t < 300);
endtask

task automatic t_regs();
    rd(IDX_CH1_ROUTE, RST_CH1_ROUTE, RESP_OKAY);
    rd(IDX_CH2_COUNTS, RST_CH2_COUNTS, RESP_OKAY);
    rd(IDX_CH2_CTRL, RST_CH2_CTRL, RESP_OKAY);
    rd(IDX_CH2_ROUTE, RST_CH2_ROUTE, RESP_OKAY);
    rd(10'h000, 8'h00, RESP_SLVERR);
    wr(IDX_CH2_COUNTS, 8'h21);
    rd(IDX_CH2_COUNTS, 8'h21, RESP_OKAY);
endtask

task automatic t_counts();
    len("high", 1, 1'b1, 8);
    len("low", 1, 1'b0, 12);
    chk("pair_b", o3a, o3b);
    wr(IDX_SRC_SEL, SRC_VCO);
    len("vco_high", 1, 1'b1, 12);
    wr(IDX_SRC_SEL, SRC_EXT);
endtask

task automatic t_force();
    wr(IDX_CH2_CTRL, 8'h80);
    len("bypass", 1, 1'b1, 2);
    wr(IDX_CH2_CTRL, 8'h60);
    steady("force_hi", 1'b1);
    wr(IDX_CH2_CTRL, 8'h20);
    len("force_nosync0", 1, 1'b1, 8);
    wr(IDX_CH2_CTRL, 8'hE0);
    len("force_bypass", 1, 1'b1, 2);
    wr(IDX_CH2_CTRL, 8'h00);
    sync_req <= 1;
    steady("held_low", 1'b0);
    wr(IDX_CH2_CTRL, 8'h40);
    len("nosync_run", 1, 1'b1, 8);
    @(posedge clk);
    sync_req <= 0;
    wr(IDX_CH2_CTRL, 8'h00);
endtask

task automatic t_route();
    wr(IDX_CH2_ROUTE, 8'h02);
    wr(IDX_SRC_SEL, SRC_VCO);
    len("direct_vco", 1, 1'b1, 3);
    wr(IDX_SRC_SEL, SRC_EXT);
    len("direct_ext", 1, 1'b1, 2);
    wr(IDX_SRC_SEL, 8'h01);
    len("direct_none", 1, 1'b1, 8);
    len("ch1_div", 0, 1'b1, 5);
    chk("pair2_b", o2a, o2b);
    wr(IDX_CH1_ROUTE, 8'h02);
    wr(IDX_SRC_SEL, SRC_VCO);
    len("ch1_vco", 0, 1'b1, 3);
    wr(IDX_SRC_SEL, SRC_EXT);
    wr(IDX_CH2_ROUTE, 8'h00);
endtask

task automatic t_start();
    int t0, t1, t2, t3;
    sync_lat(8'h10, t0);
    sync_lat(8'h00, t1);
    chk("start_low", 12, t1 - t0);
    sync_lat(8'h12, t2);
    chk("phase", 8, t2 - t0);
    wr(IDX_CH2_ROUTE, 8'h01);
    sync_lat(8'h10, t3);
    chk("dcc", 1, t0 - t3);
endtask

initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_regs();
    t_counts();
    t_force();
    t_route();
    t_start();
    stop_test();
end
endmodule // channel_clock_divider_tb
`default_nettype wire
